/* File: src/mdw_pkg.sv */
package mdw_pkg;

	// clock and timing, each time in its own unit and its derived count
	localparam int CLK_PERIOD_NS   = 8;
	localparam int PHASE_NS        = 48;
	localparam int PHASE_CYC       = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HALF_CYC        = PHASE_CYC / 2;
	localparam int INIT_WAIT_US    = 200;
	localparam int INIT_WAIT_CYC   = (INIT_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_PULSES     = 8;

	// widths of the ram port and of the sequencer counter
	localparam int ADDR_W          = 9;
	localparam int DQ_W            = 16;
	localparam int CNT_W           = 16;

	// register offsets (byte addresses on the wishbone side)
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_DATA   = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_RDATA  = 8'h10;

	// control and status field positions and reset values
	localparam int CTRL_GO_BIT     = 0;
	localparam int CTRL_OP_LSB     = 1;
	localparam int CTRL_LANE_LSB   = 4;
	localparam int CTRL_INIT_BIT   = 6;
	localparam int CTRL_CBR_BIT    = 7;
	localparam logic [7:0]  CTRL_RESET = 8'h00;
	localparam logic [17:0] ADDR_RESET = 18'h00000;
	localparam logic [31:0] DATA_RESET = 32'h00000000;
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_DONE_BIT   = 1;

	// cycle codes held in the op field
	localparam logic [2:0] READ_CODE                 = 3'h0;
	localparam logic [2:0] MASKED_WRITE_CODE         = 3'h1;
	localparam logic [2:0] NORMAL_WRITE_CODE         = 3'h2;
	localparam logic [2:0] MASKED_BLOCK_WRITE_CODE   = 3'h3;
	localparam logic [2:0] BLOCK_WRITE_CODE          = 3'h4;
	localparam logic [2:0] MASKED_FLASH_WRITE_CODE   = 3'h5;
	localparam logic [2:0] LOAD_COLOUR_REGISTER_CODE = 3'h6;
	localparam logic [2:0] REFRESH_CODE              = 3'h7;

	// ram port control pins, strobes and enables active low
	typedef struct packed {
		logic              ras_n;
		logic              cas_n;
		logic              transfer_output_enable_n;
		logic              serial_clock;
		logic              special_function_select;
		logic              write_enable_high_byte_n;
		logic              write_enable_low_byte_n;
		logic [ADDR_W-1:0] addr;
	} mdw_pins_t;

	localparam mdw_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 9'h000};

endpackage : mdw_pkg

/* File: src/mdw_dq_sample.sv */
`timescale 1ns/1ps
// brings the data pins into the clock domain and holds the read word
module mdw_dq_sample
	import mdw_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            reset_n,
	input  wire logic            ce,
	input  wire logic [DQ_W-1:0] dq_i,
	input  wire logic            cap,
	output logic      [DQ_W-1:0] rdata
);
	logic [DQ_W-1:0] meta_q, sync_q, rdata_q, meta_d, sync_d, rdata_d;

	// first stage feeds only the second; capture reads the second
	always_comb begin
		meta_d  = dq_i;
		sync_d  = meta_q;
		rdata_d = cap ? sync_q : rdata_q;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q  <= '0;
			sync_q  <= '0;
			rdata_q <= '0;
		end else if (ce) begin
			meta_q  <= meta_d;
			sync_q  <= sync_d;
			rdata_q <= rdata_d;
		end
	end

	assign rdata = rdata_q;

endmodule : mdw_dq_sample

/* File: src/mdw_ctrl.sv */
`timescale 1ns/1ps
// Summary of operation
// - wait 200 us, then 8 strobes, 8 clocks
// - refresh-counter init uses 8 cbr cycles
// - reads keep write enables high to end
// - address changes at most twice per row
// - one address change while column strobe high
module mdw_ctrl
	import mdw_pkg::*;
#(
	parameter int INIT_WAIT = INIT_WAIT_CYC
) (
	input  wire logic            clk,
	input  wire logic            reset_n,
	input  wire logic            ce,
	input  wire logic [7:0]      wb_adr_i,
	input  wire logic [31:0]     wb_dat_i,
	input  wire logic [3:0]      wb_sel_i,
	input  wire logic            wb_we_i,
	input  wire logic            wb_cyc_i,
	input  wire logic            wb_stb_i,
	output logic      [31:0]     wb_dat_o,
	output logic                 wb_ack_o,
	output mdw_pins_t            pins,
	output logic      [DQ_W-1:0] dq_o,
	output logic                 dq_oe_n,
	input  wire logic [DQ_W-1:0] dq_i
);
	if (INIT_WAIT < 1 || INIT_WAIT > 65535) begin : g_bad_wait
		$error("INIT_WAIT must lie in 1..65535");
	end

	typedef enum logic [3:0] {S_WAIT, S_INIT_HI, S_INIT_LO, S_IDLE, S_ROW, S_RAS,
		S_COL, S_CAS, S_PRE} mdw_state_t;

	localparam logic [CNT_W-1:0] PH   = CNT_W'(PHASE_CYC - 1);
	localparam logic [CNT_W-1:0] HALF = CNT_W'(HALF_CYC);
	localparam logic [CNT_W-1:0] WAIT = CNT_W'(INIT_WAIT - 1);

	mdw_state_t      st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [3:0]      npulse_q, npulse_d;
	logic            done_q, done_d, cap, last;
	mdw_pins_t       pins_q, pins_d;
	logic [DQ_W-1:0] dqo_q, dqo_d;
	logic            dqoe_q, dqoe_d;
	logic [7:0]      ctrl_q, ctrl_d;
	logic [17:0]     addr_q, addr_d;
	logic [31:0]     data_q, data_d, rdo_q, rdo_d;
	logic            ack_q, ack_d, req, commit, go, init_go;
	logic [DQ_W-1:0] rdata;
	logic [2:0]      op;
	logic [1:0]      lanes;
	logic            cbr, masked, is_read, dsf_row, dsf_col;

	// op decode; a zero lane field means both byte lanes
	assign op      = ctrl_q[CTRL_OP_LSB +: 3];
	assign cbr     = ctrl_q[CTRL_CBR_BIT];
	assign lanes   = (ctrl_q[CTRL_LANE_LSB +: 2] == 2'h0) ? 2'h3 : ctrl_q[CTRL_LANE_LSB +: 2];
	assign is_read = (op == READ_CODE);
	assign masked  = (op == MASKED_WRITE_CODE) || (op == MASKED_BLOCK_WRITE_CODE) ||
		(op == MASKED_FLASH_WRITE_CODE);
	assign dsf_row = (op == MASKED_FLASH_WRITE_CODE) ||
		(op == LOAD_COLOUR_REGISTER_CODE);
	assign dsf_col = (op == BLOCK_WRITE_CODE) || (op == MASKED_BLOCK_WRITE_CODE) ||
		(op == LOAD_COLOUR_REGISTER_CODE);
	assign last    = (cnt_q == '0);

	// wishbone slave: ack one cycle after the request, write lands on the ack edge
	assign req     = wb_cyc_i && wb_stb_i;
	assign commit  = req && ack_q && wb_we_i;
	assign go      = commit && wb_adr_i == REG_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_GO_BIT];
	assign init_go = commit && wb_adr_i == REG_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_INIT_BIT];

	always_comb begin
		ack_d  = req && !ack_q;
		ctrl_d = ctrl_q;
		addr_d = addr_q;
		data_d = data_q;
		rdo_d  = rdo_q;
		// orders are only taken while idle, so an op cannot change mid-cycle
		if (commit && st_q == S_IDLE) begin
			if (wb_adr_i == REG_CTRL && wb_sel_i[0])
				ctrl_d = wb_dat_i[7:0];
			if (wb_adr_i == REG_ADDR) begin
				for (int b = 0; b < 3; b++) begin
					if (wb_sel_i[b])
						addr_d[b*8 +: 2] = wb_dat_i[b*8 +: 2];
				end
				if (wb_sel_i[0])
					addr_d[7:0] = wb_dat_i[7:0];
				if (wb_sel_i[1])
					addr_d[15:8] = wb_dat_i[15:8];
			end
			if (wb_adr_i == REG_DATA) begin
				for (int b = 0; b < 4; b++) begin
					if (wb_sel_i[b])
						data_d[b*8 +: 8] = wb_dat_i[b*8 +: 8];
				end
			end
		end
		if (req && !ack_q) begin
			case (wb_adr_i)
				REG_CTRL:   rdo_d = {24'h000000, ctrl_q};
				REG_ADDR:   rdo_d = {14'h0000, addr_q};
				REG_DATA:   rdo_d = data_q;
				REG_STATUS: rdo_d = {30'h00000000, done_q, st_q != S_IDLE};
				REG_RDATA:  rdo_d = {16'h0000, rdata};
				default:    rdo_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_q  <= 1'b0;
			ctrl_q <= CTRL_RESET;
			addr_q <= ADDR_RESET;
			data_q <= DATA_RESET;
			rdo_q  <= 32'h00000000;
		end else if (ce) begin
			ack_q  <= ack_d;
			ctrl_q <= ctrl_d;
			addr_q <= addr_d;
			data_q <= data_d;
			rdo_q  <= rdo_d;
		end
	end

	// ram port sequencer; pins follow the state one cycle later
	always_comb begin
		st_d     = st_q;
		cnt_d    = last ? cnt_q : cnt_q - 1'b1;
		npulse_d = npulse_q;
		done_d   = done_q;
		pins_d   = PINS_IDLE;
		dqo_d    = dqo_q;
		dqoe_d   = 1'b1;
		cap      = 1'b0;
		case (st_q)
			S_WAIT: begin
				npulse_d = 4'h0;
				if (last) begin
					st_d  = S_INIT_HI;
					cnt_d = PH;
				end
			end
			S_INIT_HI: begin
				pins_d.cas_n = !(cbr && cnt_q < HALF);
				if (last) begin
					st_d  = S_INIT_LO;
					cnt_d = PH;
				end
			end
			S_INIT_LO: begin
				pins_d.ras_n        = 1'b0;                          // trg stays high
				pins_d.serial_clock = 1'b1;
				pins_d.cas_n        = !(cbr && cnt_q >= HALF);
				if (last) begin
					npulse_d = npulse_q + 1'b1;
					cnt_d    = PH;
					st_d     = (npulse_q == 4'(INIT_PULSES - 1)) ? S_IDLE : S_INIT_HI;
					done_d   = (npulse_q == 4'(INIT_PULSES - 1));
				end
			end
			S_IDLE: begin
				if (init_go) begin
					st_d   = S_WAIT;
					cnt_d  = WAIT;
					done_d = 1'b0;
				end else if (go) begin
					st_d  = S_ROW;
					cnt_d = PH;
				end
			end
			S_ROW, S_RAS: begin
				// row phase: select and enables set before the row strobe falls
				pins_d.ras_n                    = (st_q == S_ROW);
				pins_d.addr                     = addr_q[ADDR_W-1:0];
				pins_d.special_function_select  = dsf_row;
				pins_d.write_enable_low_byte_n  = !(masked && lanes[0]);
				pins_d.write_enable_high_byte_n = !(masked && lanes[1]);
				if (op == REFRESH_CODE)
					pins_d.cas_n = (st_q == S_ROW) && cnt_q >= HALF;
				if (masked) begin
					dqo_d  = data_q[31:16];
					dqoe_d = 1'b0;
				end
				if (last) begin
					cnt_d = PH;
					st_d  = (st_q == S_ROW) ? S_RAS :
						(op == REFRESH_CODE) ? S_PRE : S_COL;
				end
			end
			S_COL, S_CAS: begin
				// single address change, made while the column strobe is high
				pins_d.ras_n                    = 1'b0;
				pins_d.cas_n                    = (st_q == S_COL);
				pins_d.addr                     = addr_q[17:9];
				pins_d.special_function_select  = dsf_col;
				// enables drop before the column strobe: always an early write
				pins_d.write_enable_low_byte_n  = is_read || !lanes[0];
				pins_d.write_enable_high_byte_n = is_read || !lanes[1];
				pins_d.transfer_output_enable_n = !is_read;
				dqo_d  = data_q[15:0];
				dqoe_d = is_read;
				if (last) begin
					cap   = is_read && st_q == S_CAS;
					cnt_d = PH;
					st_d  = (st_q == S_COL) ? S_CAS : S_PRE;
				end
			end
			S_PRE: begin
				if (last)
					st_d = S_IDLE;
			end
			default: st_d = S_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q     <= S_WAIT;
			cnt_q    <= WAIT;
			npulse_q <= 4'h0;
			done_q   <= 1'b0;
			pins_q   <= PINS_IDLE;
			dqo_q    <= '0;
			dqoe_q   <= 1'b1;
		end else if (ce) begin
			st_q     <= st_d;
			cnt_q    <= cnt_d;
			npulse_q <= npulse_d;
			done_q   <= done_d;
			pins_q   <= pins_d;
			dqo_q    <= dqo_d;
			dqoe_q   <= dqoe_d;
		end
	end

	mdw_dq_sample u_sample (
		.clk     (clk),
		.reset_n (reset_n),
		.ce      (ce),
		.dq_i    (dq_i),
		.cap     (cap),
		.rdata   (rdata)
	);

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdo_q;
	assign pins     = pins_q;
	assign dq_o     = dqo_q;
	assign dq_oe_n  = dqoe_q;

	// checker helpers: wait length, init pulse count, address changes per row
	logic [CNT_W-1:0] wait_len_q;
	logic [3:0]       rfall_q, chg_q, chg_hi_q;
	logic [ADDR_W-1:0] prev_addr_q;
	logic             prev_ras_q, prev_cas_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wait_len_q  <= '0;
			rfall_q     <= 4'h0;
			chg_q       <= 4'h0;
			chg_hi_q    <= 4'h0;
			prev_addr_q <= '0;
			prev_ras_q  <= 1'b1;
			prev_cas_q  <= 1'b1;
		end else if (ce) begin
			// helpers freeze with the rest of the state so a held clock enable reads no edges
			prev_addr_q <= pins_q.addr;
			prev_ras_q  <= pins_q.ras_n;
			prev_cas_q  <= pins_q.cas_n;
			wait_len_q  <= (st_q == S_WAIT) ? wait_len_q + 1'b1 :
				(st_q == S_IDLE) ? '0 : wait_len_q;
			rfall_q     <= (st_q == S_WAIT) ? 4'h0 :
				rfall_q + 4'(!pins_q.ras_n && prev_ras_q && !done_q);
			chg_q       <= pins_q.ras_n ? 4'h0 : chg_q + 4'(pins_q.addr != prev_addr_q);
			chg_hi_q    <= (pins_q.ras_n || !pins_q.cas_n) ? 4'h0 :
				chg_hi_q + 4'(pins_q.addr != prev_addr_q && !prev_ras_q && prev_cas_q);
		end
	end

	property p_init_wait;
		@(posedge clk) disable iff (!reset_n)
		(st_q == S_INIT_HI && $past(st_q) == S_WAIT) |-> wait_len_q >= CNT_W'(INIT_WAIT);
	endproperty
	a_init_wait: assert property (p_init_wait) else $error("init began before the wait");

	property p_init_pulses;
		@(posedge clk) disable iff (!reset_n)
		$rose(done_q) |-> ##2 (rfall_q == 4'(INIT_PULSES));
	endproperty
	a_init_pulses: assert property (p_init_pulses) else $error("init pulse count wrong");

	property p_init_cbr;
		@(posedge clk) disable iff (!reset_n)
		($fell(pins_q.ras_n) && !done_q && cbr) |-> !pins_q.cas_n && !$past(pins_q.cas_n);
	endproperty
	a_init_cbr: assert property (p_init_cbr) else $error("init cycle not cbr");

	property p_read_we;
		@(posedge clk) disable iff (!reset_n)
		($fell(pins_q.ras_n) && done_q && is_read) |->
			(pins_q.write_enable_low_byte_n && pins_q.write_enable_high_byte_n)
			throughout (!pins_q.ras_n [*8]);
	endproperty
	a_read_we: assert property (p_read_we) else $error("write enable low in read");

	property p_addr_twice;
		@(posedge clk) disable iff (!reset_n)
		!pins_q.ras_n |-> chg_q <= 4'h2;
	endproperty
	a_addr_twice: assert property (p_addr_twice) else $error("address changed too often");

	property p_addr_cas_high;
		@(posedge clk) disable iff (!reset_n)
		(!pins_q.ras_n && pins_q.cas_n) |-> chg_hi_q <= 4'h1;
	endproperty
	a_addr_cas_high: assert property (p_addr_cas_high) else $error("two changes with cas high");

	property p_early_write;
		@(posedge clk) disable iff (!reset_n)
		($fell(pins_q.cas_n) && !pins_q.ras_n && !is_read) |->
			!($past(pins_q.write_enable_low_byte_n, 2) && $past(pins_q.write_enable_high_byte_n, 2));
	endproperty
	a_early_write: assert property (p_early_write) else $error("write enable late");

	property p_flash;
		@(posedge clk) disable iff (!reset_n)
		($fell(pins_q.ras_n) && done_q && op == MASKED_FLASH_WRITE_CODE) |->
			pins_q.special_function_select && !dq_oe_n && dq_o == data_q[31:16];
	endproperty
	a_flash: assert property (p_flash) else $error("flash write code wrong");

	property p_colour;
		@(posedge clk) disable iff (!reset_n)
		($fell(pins_q.cas_n) && !pins_q.ras_n && op == LOAD_COLOUR_REGISTER_CODE) |->
			pins_q.special_function_select && dq_o == data_q[15:0];
	endproperty
	a_colour: assert property (p_colour) else $error("load colour code wrong");

endmodule : mdw_ctrl

/* File: tb/mdw_ram_model.sv */
`timescale 1ns/1ps
// behavioural ram port of the multiport dram with its write mode decode
module mdw_ram_model
	import mdw_pkg::*;
(
	input  wire mdw_pins_t       pins,
	input  wire logic [DQ_W-1:0] dq_o,
	input  wire logic            dq_oe_n,
	output logic      [DQ_W-1:0] dq_i,
	output int                   n_ras,
	output int                   n_sc,
	output int                   n_cbr,
	output int                   n_viol
);
	logic [15:0] mem [logic [17:0]];
	logic [15:0] colour = 16'h0;
	logic [15:0] last = 16'h0;
	logic [15:0] wmask, rd, en;
	logic        dsf_r, wpb_r;
	logic        rd_on = 1'b0;
	logic [8:0]  row;
	int          chg, chg_c;
	int          ras_cnt = 0, sc_cnt = 0, cbr_cnt = 0, viol_we = 0, viol_adr = 0;

	// counters live inside so that each output port has a single driver
	assign n_ras  = ras_cnt;
	assign n_sc   = sc_cnt;
	assign n_cbr  = cbr_cnt;
	assign n_viol = viol_we + viol_adr;

	function automatic logic [15:0] rdm(input logic [17:0] a);
		return mem.exists(a) ? mem[a] : 16'h0;
	endfunction : rdm

	task automatic put(input logic [17:0] a, input logic [15:0] d, input logic [15:0] msk);
		mem[a] = (rdm(a) & ~msk) | (d & msk);
	endtask : put

	// no pull on the data lines, so a released bus shows the inverse of its last value
	assign dq_i = !dq_oe_n ? dq_o : (rd_on ? rd : ~last);
	always @(dq_o or dq_oe_n) if (!dq_oe_n) last = dq_o;

	// mode, write mask and row are latched as the row strobe falls
	always @(negedge pins.ras_n) begin
		row = pins.addr;
		dsf_r = pins.special_function_select;
		wpb_r = !(pins.write_enable_low_byte_n && pins.write_enable_high_byte_n);
		wmask = wpb_r ? dq_i : 16'hffff;
		chg = 0;
		chg_c = 0;
		if (pins.transfer_output_enable_n) ras_cnt++;
		if (!pins.cas_n) cbr_cnt++;
		if (pins.cas_n && dsf_r && wpb_r) begin
			for (int c = 0; c < 512; c++) put({9'(c), row}, colour, wmask);
		end
	end

	// column strobe picks the function from the second select sample
	always @(negedge pins.cas_n) if (!pins.ras_n) begin
		en = {{8{!pins.write_enable_high_byte_n}}, {8{!pins.write_enable_low_byte_n}}};
		if (dsf_r) begin
			if (!wpb_r && pins.special_function_select) colour = dq_i;
		end else if (pins.special_function_select) begin
			for (int k = 0; k < 8; k++)
				put({pins.addr[8:3], 3'(k), row}, colour, wmask & en & {{8{dq_i[k+8]}}, {8{dq_i[k]}}});
		end else if (en != 16'h0) put({pins.addr, row}, dq_i, wmask & en);
		else begin
			rd = rdm({pins.addr, row});
			rd_on = !pins.transfer_output_enable_n;
		end
	end

	always @(posedge pins.cas_n or posedge pins.ras_n) begin
		rd_on = 1'b0;
		chg_c = 0;
	end

	// controller-side hazards are only counted; the bench judges the total
	always @(pins.write_enable_low_byte_n or pins.write_enable_high_byte_n)
		if (rd_on) viol_we++;
	always @(pins.addr) if (!pins.ras_n) begin
		chg++;
		if (pins.cas_n) chg_c++;
		if (chg > 2 || chg_c > 1) viol_adr++;
	end
	always @(posedge pins.serial_clock) sc_cnt++;
endmodule : mdw_ram_model

/* File: tb/test_multiport_dram_write_mode_decode.sv */
`timescale 1ns/1ps
// drives the controller over wishbone against the behavioural dram
module test_multiport_dram_write_mode_decode;
	import mdw_pkg::*;
	// short power-up wait keeps the run brief
	localparam int IW = 20;
	logic            clk, reset_n, ce;
	logic            wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, dq_oe_n;
	logic [7:0]      wb_adr_i;
	logic [3:0]      wb_sel_i;
	logic [31:0]     wb_dat_i, wb_dat_o, rv;
	logic [DQ_W-1:0] dq_o, dq_i;
	mdw_pins_t       pins;
	int              n_ras, n_sc, n_cbr, n_viol, miscompares, n_tests;

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	mdw_ctrl #(.INIT_WAIT(IW)) dut_u (
		.clk(clk), .reset_n(reset_n), .ce(ce), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins(pins), .dq_o(dq_o),
		.dq_oe_n(dq_oe_n), .dq_i(dq_i));

	mdw_ram_model mdl_u (
		.pins(pins), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dq_i(dq_i), .n_ras(n_ras),
		.n_sc(n_sc), .n_cbr(n_cbr), .n_viol(n_viol));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask : chk

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	// one classic cycle; request held until ack is sampled, then dropped a cycle
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int i;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= 4'hf;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 50);
		if (i >= 50) begin
			miscompares++;
			wrap_up();
		end
		rv = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask : wb

	task automatic poll(input int b, input logic v);
		for (int i = 0; i < 3000; i++) begin
			wb(1'b0, REG_STATUS, 32'h0);
			if (rv[b] === v) return;
		end
		miscompares++;
		wrap_up();
	endtask : poll

	task automatic op(input logic [2:0] code, input logic [1:0] ln, input logic [17:0] a,
			input logic [31:0] d);
		wb(1'b1, REG_ADDR, {14'h0, a});
		wb(1'b1, REG_DATA, d);
		wb(1'b1, REG_CTRL, {24'h0, 2'b00, ln, code, 1'b1});
		poll(STAT_BUSY_BIT, 1'b0);
	endtask : op

	task automatic expect_at(input logic [17:0] a, input logic [15:0] exp);
		op(READ_CODE, 2'b00, a, 32'h0);
		wb(1'b0, REG_RDATA, 32'h0);
		chk(rv, {16'h0, exp});
	endtask : expect_at

	// idle pins in reset, no row strobe during the wait, then eight pulses
	task automatic t_reset;
		chk(32'(pins), 32'(PINS_IDLE));
		reset_n <= 1'b1;
		repeat (IW - 1) @(posedge clk);
		chk(32'(n_ras), 32'h0);
		wb(1'b0, REG_CTRL, 32'h0);
		chk(rv, {24'h0, CTRL_RESET});
		wb(1'b0, REG_ADDR, 32'h0);
		chk(rv, {14'h0, ADDR_RESET});
		wb(1'b0, 8'h14, 32'h0);
		chk(rv, 32'h0);
		poll(STAT_DONE_BIT, 1'b1);
		chk(32'(n_ras), 32'(INIT_PULSES));
		chk(32'(n_sc), 32'(INIT_PULSES));
		$display("reset test done");
	endtask : t_reset

	// plain, masked and single-lane writes to one cell, each read back
	task automatic t_write;
		op(NORMAL_WRITE_CODE, 2'b00, {9'd5, 9'd3}, 32'h00001234);
		expect_at({9'd5, 9'd3}, 16'h1234);
		op(MASKED_WRITE_CODE, 2'b00, {9'd5, 9'd3}, 32'h00ffabcd);
		expect_at({9'd5, 9'd3}, 16'h12cd);
		op(NORMAL_WRITE_CODE, 2'b01, {9'd5, 9'd3}, 32'h00007777);
		expect_at({9'd5, 9'd3}, 16'h1277);
		op(NORMAL_WRITE_CODE, 2'b10, {9'd5, 9'd3}, 32'h00008888);
		expect_at({9'd5, 9'd3}, 16'h8877);
		$display("write test done");
	endtask : t_write

	// colour load, then block writes whose data picks columns per lane
	task automatic t_block;
		op(LOAD_COLOUR_REGISTER_CODE, 2'b00, 18'h0, 32'h00005a5a);
		op(BLOCK_WRITE_CODE, 2'b00, {9'd10, 9'd3}, 32'h00000401);
		expect_at({9'd8, 9'd3}, 16'h005a);
		expect_at({9'd9, 9'd3}, 16'h0000);
		expect_at({9'd10, 9'd3}, 16'h5a00);
		op(MASKED_BLOCK_WRITE_CODE, 2'b00, {9'd16, 9'd3}, 32'h0f0fffff);
		expect_at({9'd17, 9'd3}, 16'h0a0a);
		$display("block test done");
	endtask : t_block

	// masked flash fills a whole row from the latest colour
	task automatic t_flash;
		op(LOAD_COLOUR_REGISTER_CODE, 2'b00, 18'h0, 32'h0000c3c3);
		op(MASKED_FLASH_WRITE_CODE, 2'b00, {9'd0, 9'd7}, 32'hff000000);
		expect_at({9'd100, 9'd7}, 16'hc300);
		$display("flash test done");
	endtask : t_flash

	// rerun of initialisation with the internal refresh counter
	task automatic t_cbr;
		wb(1'b1, REG_CTRL, 32'h000000c0);
		poll(STAT_DONE_BIT, 1'b0);
		poll(STAT_DONE_BIT, 1'b1);
		chk(32'(n_cbr), 32'(INIT_PULSES));
		// a single refresh op adds one more column-before-row cycle
		op(REFRESH_CODE, 2'b00, 18'h0, 32'h0);
		chk(32'(n_cbr), 32'(INIT_PULSES + 1));
		chk(32'(n_viol), 32'h0);
		$display("refresh init test done");
	endtask : t_cbr

	initial begin
		miscompares = 0;
		n_tests = 0;
		ce = 1'b1;
		reset_n = 1'b0;
		wb_we_i = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'h0;
		repeat (12) @(posedge clk);
		t_reset();
		t_write();
		t_block();
		t_flash();
		t_cbr();
		wrap_up();
	end
endmodule : test_multiport_dram_write_mode_decode
